/* File: dpsf_pkg.sv */
// constants and types shared by the semaphore port controller
package dpsf_pkg;
  localparam int unsigned FLAG_COUNT    = 8;
  localparam int unsigned INDEX_WIDTH   = 3;
  localparam int unsigned ADDR_WIDTH    = 17;
  localparam int unsigned DATA_WIDTH    = 8;
  localparam int unsigned CORE_CLK_MHZ  = 125;
  // pin access phase times in ns
  localparam int unsigned SETUP_NS      = 16;
  localparam int unsigned STROBE_NS     = 40;
  localparam int unsigned RECOVER_NS    = 16;
  localparam int unsigned SETUP_CYCLES  = (SETUP_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned STROBE_CYCLES = (STROBE_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned RECOVER_CYCLES = (RECOVER_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned COUNT_WIDTH   = 4;
  localparam logic [7:0] INIT_STEPS     = 8'h10;
  localparam logic [7:0] DATA_RELEASE   = 8'hff;
  localparam logic [7:0] DATA_REQUEST   = 8'h00;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 4'h0;

  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_REQUEST = 3'h1,
    OP_RELEASE = 3'h2,
    OP_READ    = 3'h3,
    OP_ACQUIRE = 3'h4
  } dpsf_op_type;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_SETUP   = 6'h02,
    ST_STROBE  = 6'h04,
    ST_RECOVER = 6'h08,
    ST_DECIDE  = 6'h10,
    ST_INIT    = 6'h20
  } dpsf_state_type;
endpackage

/* File: dpsf_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module dpsf_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_srst,
  // pin and filtered value
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_value
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] value;
  logic [WIDTH-1:0] next_value;

  // per bit: change taken once second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_comb begin
        next_value[gi] = (stage2[gi] == stage3[gi]) ? stage3[gi] : value[gi];
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
      value  <= '1;
    end else begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
      value  <= next_value;
    end
  end

  assign o_value = value;
endmodule

/* File: dpsf_port_ctrl.sv */
// controller for one port of a dual-port semaphore flag device
`timescale 1ns/1ns
module dpsf_port_ctrl (
  // clock and reset
  input  wire logic                          i_core_clk,
  input  wire logic                          i_srst,
  // command port
  input  wire logic                          i_cmd_valid,
  input  wire dpsf_pkg::dpsf_op_type         i_cmd_op,
  input  wire logic [dpsf_pkg::INDEX_WIDTH-1:0] i_cmd_index,
  output logic                               o_cmd_ready,
  output logic                               o_done,
  output logic                               o_granted,
  output logic                               o_flag_value,
  output logic                               o_init_busy,
  // device pins
  output logic                               o_flag_space_select_n,
  output logic                               o_chip_enable_n,
  output logic                               o_output_enable_n,
  output logic                               o_read_write,
  output logic [dpsf_pkg::ADDR_WIDTH-1:0]    o_addr,
  output logic [dpsf_pkg::DATA_WIDTH-1:0]    o_data_out,
  output logic [dpsf_pkg::DATA_WIDTH-1:0]    o_data_oe_n,
  input  wire logic [dpsf_pkg::DATA_WIDTH-1:0] i_data_in
);
  logic [dpsf_pkg::DATA_WIDTH-1:0] data_sync;

  dpsf_sync #(
    .WIDTH (dpsf_pkg::DATA_WIDTH)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_pin      (i_data_in),
    .o_value    (data_sync)
  );

  dpsf_pkg::dpsf_state_type          state;
  dpsf_pkg::dpsf_state_type          next_state;
  dpsf_pkg::dpsf_op_type             op;
  dpsf_pkg::dpsf_op_type             next_op;
  logic                              is_write;
  logic                              next_is_write;
  logic                              wr_bit;
  logic                              next_wr_bit;
  logic [dpsf_pkg::INDEX_WIDTH-1:0]  index;
  logic [dpsf_pkg::INDEX_WIDTH-1:0]  next_index;
  logic [dpsf_pkg::COUNT_WIDTH-1:0]  count;
  logic [dpsf_pkg::COUNT_WIDTH-1:0]  next_count;
  logic [7:0]                        init_step;
  logic [7:0]                        next_init_step;
  logic                              cmd_ready;
  logic                              next_cmd_ready;
  logic                              done;
  logic                              next_done;
  logic                              granted;
  logic                              next_granted;
  logic                              flag_value;
  logic                              next_flag_value;
  logic                              init_busy;
  logic                              next_init_busy;
  logic                              sel_n;
  logic                              next_sel_n;
  logic                              oe_n;
  logic                              next_oe_n;
  logic                              rw;
  logic                              next_rw;
  logic                              drive_n;
  logic                              next_drive_n;
  logic                              read_flag;

  // device replicates the flag on all bits; a mixed read counts as zero, so granted
  assign read_flag = &data_sync;

  always_comb begin
    next_state      = state;
    next_op         = op;
    next_is_write   = is_write;
    next_wr_bit     = wr_bit;
    next_index      = index;
    next_count      = count;
    next_init_step  = init_step;
    next_cmd_ready  = 1'b0;
    next_done       = 1'b0;
    next_granted    = granted;
    next_flag_value = flag_value;
    next_init_busy  = init_busy;
    next_sel_n      = sel_n;
    next_oe_n       = oe_n;
    next_rw         = rw;
    next_drive_n    = drive_n;
    case (state)
      dpsf_pkg::ST_INIT: begin
        // write one to every flag before taking commands
        if (init_step == dpsf_pkg::INIT_STEPS[7:0] >> 1) begin
          next_init_busy = 1'b0;
          next_cmd_ready = 1'b1;
          next_state     = dpsf_pkg::ST_IDLE;
        end else begin
          next_op        = dpsf_pkg::OP_RELEASE;
          next_is_write  = 1'b1;
          next_wr_bit    = 1'b1;
          next_index     = init_step[dpsf_pkg::INDEX_WIDTH-1:0];
          next_init_step = init_step + 8'h01;
          next_count     = dpsf_pkg::COUNT_ZERO;
          next_state     = dpsf_pkg::ST_SETUP;
        end
      end
      dpsf_pkg::ST_IDLE: begin
        next_cmd_ready = 1'b1;
        if (i_cmd_valid && i_cmd_op != dpsf_pkg::OP_NONE) begin
          next_cmd_ready = 1'b0;
          next_op        = i_cmd_op;
          next_index     = i_cmd_index;
          next_is_write  = (i_cmd_op != dpsf_pkg::OP_READ);
          next_wr_bit    = (i_cmd_op == dpsf_pkg::OP_RELEASE);
          next_count     = dpsf_pkg::COUNT_ZERO;
          next_state     = dpsf_pkg::ST_SETUP;
        end
      end
      dpsf_pkg::ST_SETUP: begin
        // address and data settle with select low and chip enable high
        next_sel_n   = 1'b0;
        next_rw      = ~is_write;
        next_drive_n = ~is_write;
        next_count   = count + 4'h1;
        if (count == 4'(dpsf_pkg::SETUP_CYCLES - 1)) begin
          next_count = dpsf_pkg::COUNT_ZERO;
          next_oe_n  = is_write;
          next_state = dpsf_pkg::ST_STROBE;
        end
      end
      dpsf_pkg::ST_STROBE: begin
        next_count = count + 4'h1;
        if (is_write) begin
          next_rw = 1'b0;
        end
        if (count == 4'(dpsf_pkg::STROBE_CYCLES - 1)) begin
          next_count = dpsf_pkg::COUNT_ZERO;
          next_rw    = 1'b1;
          next_sel_n = 1'b1;
          next_oe_n  = 1'b1;
          next_state = dpsf_pkg::ST_RECOVER;
        end
      end
      dpsf_pkg::ST_RECOVER: begin
        next_drive_n = 1'b1;
        next_count   = count + 4'h1;
        if (count == 4'(dpsf_pkg::RECOVER_CYCLES - 1)) begin
          next_count = dpsf_pkg::COUNT_ZERO;
          next_state = dpsf_pkg::ST_DECIDE;
        end
      end
      dpsf_pkg::ST_DECIDE: begin
        if (init_busy) begin
          next_state = dpsf_pkg::ST_INIT;
        end else if (op == dpsf_pkg::OP_ACQUIRE && is_write) begin
          // write zero first, then read back to learn ownership
          next_is_write = 1'b0;
          next_state    = dpsf_pkg::ST_SETUP;
        end else begin
          if (!is_write) begin
            // stable value latched by the device during the read
            next_flag_value = read_flag;
            next_granted    = ~read_flag;
          end else begin
            next_granted = 1'b0;
          end
          // a failed request stays pending until granted or released
          next_done      = 1'b1;
          next_cmd_ready = 1'b1;
          next_state     = dpsf_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = dpsf_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state      <= dpsf_pkg::ST_INIT;
      op         <= dpsf_pkg::OP_NONE;
      is_write   <= 1'b0;
      wr_bit     <= 1'b1;
      index      <= '0;
      count      <= dpsf_pkg::COUNT_ZERO;
      init_step  <= 8'h00;
      cmd_ready  <= 1'b0;
      done       <= 1'b0;
      granted    <= 1'b0;
      flag_value <= 1'b1;
      init_busy  <= 1'b1;
      sel_n      <= 1'b1;
      oe_n       <= 1'b1;
      rw         <= 1'b1;
      drive_n    <= 1'b1;
    end else begin
      state      <= next_state;
      op         <= next_op;
      is_write   <= next_is_write;
      wr_bit     <= next_wr_bit;
      index      <= next_index;
      count      <= next_count;
      init_step  <= next_init_step;
      cmd_ready  <= next_cmd_ready;
      done       <= next_done;
      granted    <= next_granted;
      flag_value <= next_flag_value;
      init_busy  <= next_init_busy;
      sel_n      <= next_sel_n;
      oe_n       <= next_oe_n;
      rw         <= next_rw;
      drive_n    <= next_drive_n;
    end
  end

  assign o_cmd_ready           = cmd_ready;
  assign o_done                = done;
  assign o_granted             = granted;
  assign o_flag_value          = flag_value;
  assign o_init_busy           = init_busy;
  assign o_flag_space_select_n = sel_n;
  assign o_chip_enable_n       = 1'b1;
  assign o_output_enable_n     = oe_n;
  assign o_read_write          = rw;
  // upper address lines have no effect on flags; held at zero
  assign o_addr      = {{(dpsf_pkg::ADDR_WIDTH-dpsf_pkg::INDEX_WIDTH){1'b0}}, index};
  // only bit zero matters to the device; release and request drive all bits alike
  assign o_data_out  = {dpsf_pkg::DATA_WIDTH{wr_bit}};
  assign o_data_oe_n = {dpsf_pkg::DATA_WIDTH{drive_n}};
endmodule

/* File: dpsf_checker.sv */
// pin-level and command-port assertions for the semaphore port controller
`timescale 1ns/1ns
module dpsf_checker (
  // clock and reset
  input wire logic                              i_core_clk,
  input wire logic                              i_srst,
  // command port
  input wire logic                              i_cmd_valid,
  input wire dpsf_pkg::dpsf_op_type             i_cmd_op,
  input wire logic                              o_cmd_ready,
  input wire logic                              o_done,
  input wire logic                              o_granted,
  input wire logic                              o_flag_value,
  input wire logic                              o_init_busy,
  // device pins
  input wire logic                              o_flag_space_select_n,
  input wire logic                              o_chip_enable_n,
  input wire logic                              o_output_enable_n,
  input wire logic                              o_read_write,
  input wire logic [dpsf_pkg::ADDR_WIDTH-1:0]   o_addr,
  input wire logic [dpsf_pkg::DATA_WIDTH-1:0]   o_data_out,
  input wire logic [dpsf_pkg::DATA_WIDTH-1:0]   o_data_oe_n
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  a_chip_en_off: assert property (o_chip_enable_n)
    else $error("chip enable low");
  a_upper_addr: assert property (!o_flag_space_select_n |-> o_addr[16:3] == 14'h0)
    else $error("upper address bits set");
  a_write_code: assert property (!o_flag_space_select_n && !o_read_write |->
    (o_data_out == 8'hff || o_data_out == 8'h00) && o_data_oe_n == 8'h00)
    else $error("bad write data");
  a_read_float: assert property (!o_output_enable_n |->
    !o_flag_space_select_n && o_read_write && o_data_oe_n == 8'hff)
    else $error("bad read strobe");
  a_read_end: assert property ($fell(o_output_enable_n) |-> ##[4:8] $rose(o_output_enable_n))
    else $error("read strobe not ended");
  a_select_gap: assert property ($rose(o_flag_space_select_n) |-> o_flag_space_select_n[*2])
    else $error("select gap too short");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than a cycle");
  a_take_cmd: assert property (o_cmd_ready && i_cmd_valid && i_cmd_op != dpsf_pkg::OP_NONE
    |=> !o_cmd_ready ##[0:3] !o_flag_space_select_n)
    else $error("command not started");
  a_none_ignored: assert property (o_cmd_ready && i_cmd_valid && i_cmd_op == dpsf_pkg::OP_NONE
    |=> o_cmd_ready)
    else $error("empty command taken");
  a_init_start: assert property ($fell(i_srst) |-> o_init_busy && !o_cmd_ready)
    else $error("no power-up release");
  a_grant_flag: assert property (o_granted |-> !o_flag_value)
    else $error("granted with flag one");
  c_read: cover property ($fell(o_output_enable_n));
  c_grant: cover property (o_done && o_granted);
  c_init: cover property ($fell(o_init_busy));
endmodule
bind dpsf_port_ctrl dpsf_checker u_chk (.*);

/* File: dpsf_dev_model.sv */
// behavioural flag device: this port on pins, far port through tasks
`timescale 1ns/1ns
module dpsf_dev_model (
  // device pins
  input  wire logic        i_sel_n,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_rw,
  input  wire logic [16:0] i_addr,
  input  wire logic [7:0]  i_dq,
  output logic      [7:0]  o_dq
);
  logic [7:0] req_a = 8'h00; // stale latches on this side at power-up
  logic [7:0] req_b = 8'hff;
  logic [1:0] own [8];
  logic       wr_a, rd_a, bit_a, held, drv;
  assign wr_a = !i_sel_n && i_ce_n && !i_rw;
  assign rd_a = !i_sel_n && i_ce_n && !i_oe_n && i_rw;
  // 0 free, 1 this port, 2 far port
  function automatic void settle(input int i);
    case (own[i])
      2'd0: if (!req_a[i]) own[i] = 2'd1; else if (!req_b[i]) own[i] = 2'd2;
      2'd1: if (req_a[i]) own[i] = req_b[i] ? 2'd0 : 2'd2;
      default: if (req_b[i]) own[i] = req_a[i] ? 2'd0 : 2'd1;
    endcase
  endfunction
  initial begin
    bit_a = 1'bx;
    held = 1'b1;
    drv = 1'b0;
    for (int i = 0; i < 8; i++) begin
      own[i] = 2'd0;
      settle(i);
    end
  end
  always @* if (wr_a) bit_a = i_dq[0];
  always @(negedge wr_a) begin
    if (bit_a !== 1'bx) begin
      req_a[i_addr[2:0]] = bit_a;
      settle(int'(i_addr[2:0]));
    end
  end
  always @(posedge rd_a) begin
    held = (own[i_addr[2:0]] != 2'd1);
    drv = 1'b1;
  end
  // data held briefly after the strobe, then the bus shows rubbish
  // released before the next read strobe can start, so the two never meet
  always @(negedge rd_a) drv <= #20 1'b0;
  assign o_dq = drv ? {8{held}} : {8{~held}};
  task automatic b_write(input logic [2:0] i, input logic v);
    req_b[i] = v;
    settle(int'(i));
  endtask
  function automatic logic b_flag(input logic [2:0] i);
    return own[i] != 2'd2;
  endfunction
endmodule

/* File: dual_port_semaphore_flags_tb.sv */
// self-checking bench for the semaphore port controller
`timescale 1ns/1ns
module dual_port_semaphore_flags_tb;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic cmd_valid = 1'b0;
  dpsf_pkg::dpsf_op_type cmd_op = dpsf_pkg::OP_NONE;
  logic [2:0] cmd_index = 3'h0;
  logic ready, done, granted, flag, busy, sel_n, ce_n, oe_n, rw;
  logic [16:0] addr;
  logic [7:0] dq_out, dq_oe_n, dq_in;
  int errors = 0;
  int compares = 0;
  always #4 i_core_clk = ~i_core_clk;
  dpsf_port_ctrl dut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_cmd_valid(cmd_valid),
    .i_cmd_op(cmd_op), .i_cmd_index(cmd_index), .o_cmd_ready(ready), .o_done(done),
    .o_granted(granted), .o_flag_value(flag), .o_init_busy(busy),
    .o_flag_space_select_n(sel_n), .o_chip_enable_n(ce_n), .o_output_enable_n(oe_n),
    .o_read_write(rw), .o_addr(addr), .o_data_out(dq_out), .o_data_oe_n(dq_oe_n),
    .i_data_in(dq_in));
  dpsf_dev_model dev (.i_sel_n(sel_n), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_rw(rw),
    .i_addr(addr), .i_dq(dq_out), .o_dq(dq_in));
  task automatic finish_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic hang();
    errors++;
    $display("MISMATCH at %0t: wait ran out", $time);
    finish_test();
  endtask
  task automatic run_cmd(input dpsf_pkg::dpsf_op_type op, input logic [2:0] idx);
    int n;
    n = 0;
    while (ready !== 1'b1) begin
      @(negedge i_core_clk);
      if (++n > 400) hang();
    end
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_index = idx;
    @(negedge i_core_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1) begin
      @(negedge i_core_clk);
      if (++n > 40) hang();
    end
  endtask
  task automatic t_init();
    run_cmd(dpsf_pkg::OP_READ, 3'h0);
    check_bit(busy, 1'b0);
    for (int i = 0; i < 8; i++) begin
      dev.b_write(i[2:0], 1'b0);
      check_bit(dev.b_flag(i[2:0]), 1'b0);
      dev.b_write(i[2:0], 1'b1);
    end
  endtask
  task automatic t_handover();
    run_cmd(dpsf_pkg::OP_ACQUIRE, 3'h2);
    check_bit(granted, 1'b1);
    check_bit(flag, 1'b0);
    check_bit(dev.b_flag(3'h2), 1'b1);
    dev.b_write(3'h2, 1'b0);
    check_bit(dev.b_flag(3'h2), 1'b1);
    run_cmd(dpsf_pkg::OP_RELEASE, 3'h2);
    check_bit(dev.b_flag(3'h2), 1'b0);
    run_cmd(dpsf_pkg::OP_ACQUIRE, 3'h2);
    check_bit(granted, 1'b0);
    dev.b_write(3'h2, 1'b1);
    run_cmd(dpsf_pkg::OP_READ, 3'h2);
    check_bit(flag, 1'b0);
    run_cmd(dpsf_pkg::OP_RELEASE, 3'h2);
    run_cmd(dpsf_pkg::OP_READ, 3'h2);
    check_bit(flag, 1'b1);
    check_bit(dev.b_flag(3'h2), 1'b1);
  endtask
  task automatic t_read_hold();
    int n;
    dev.b_write(3'h7, 1'b0);
    run_cmd(dpsf_pkg::OP_REQUEST, 3'h7);
    fork
      run_cmd(dpsf_pkg::OP_READ, 3'h7);
      begin
        n = 0;
        while (oe_n !== 1'b0) begin
          @(negedge i_core_clk);
          if (++n > 40) hang();
        end
        dev.b_write(3'h7, 1'b1);
      end
    join
    check_bit(flag, 1'b1);
    run_cmd(dpsf_pkg::OP_READ, 3'h7);
    check_bit(flag, 1'b0);
    run_cmd(dpsf_pkg::OP_RELEASE, 3'h7);
  endtask
  task automatic t_refuse();
    logic seen;
    seen = 1'b0;
    cmd_valid = 1'b1;
    cmd_op = dpsf_pkg::OP_NONE;
    repeat (20) begin
      @(negedge i_core_clk);
      if (done === 1'b1) seen = 1'b1;
    end
    cmd_valid = 1'b0;
    check_bit(seen, 1'b0);
    check_bit(ready, 1'b1);
  endtask
  initial begin
    repeat (6) @(negedge i_core_clk);
    i_srst = 1'b0;
    t_init();
    t_handover();
    t_read_hold();
    t_refuse();
    finish_test();
  end
endmodule
